// >>> iff_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host link receiver model
// ****************************************************************
module iff_host
  import iff_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          stall,
  input  wire logic          slow,
  input  wire logic          pixel_valid_flag,
  input  wire logic [1:0]    out_colour,
  input  wire logic [DW-1:0] out_pix,
  output logic               out_ready
);
  logic [13:0] got [0:63];
  int          n;
  logic        tgl;
  // ready drops while stalled, and every other cycle when slow
  assign out_ready = !stall && !(slow && tgl);
  // capture only pixels that are flagged and taken
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      n   <= 0;
      tgl <= 1'b0;
    end else begin
      tgl <= ~tgl;
      if (pixel_valid_flag && out_ready) begin
        got[n] <= {out_colour, out_pix};
        n      <= n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> iff_pkg.sv
package iff_pkg;

  // ****************************************************************
  // geometry and buffer
  // ****************************************************************
  localparam int DW     = 12;         // pixel width
  localparam int MAXW   = 16;         // stored pixels per line
  localparam int MAXH   = 8;          // stored lines per frame
  localparam int SLOTS  = 4;          // frame slots in memory
  localparam int MEMW   = 512;        // memory words
  localparam logic [2:0] SLOTS_C = 3'h4;
  localparam logic [4:0] MAXW_C  = 5'h10;
  localparam logic [3:0] MAXH_C  = 4'h8;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_GAIN   = 8'h04;
  localparam logic [7:0] A_OFSMAX = 8'h08;
  localparam logic [7:0] A_GAP    = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_ISTAT  = 8'h14;
  localparam logic [7:0] A_IMASK  = 8'h18;

  // control fields
  localparam int C_MIR_H = 0;
  localparam int C_MIR_V = 1;
  localparam int C_BIN_H = 2;
  localparam int C_BIN_V = 3;
  localparam int C_DEC   = 4;
  localparam int C_PV_EN = 5;

  // interrupt fields
  localparam int I_DROP   = 0;
  localparam int I_STORED = 1;
  localparam int I_SENT   = 2;

  // reset values
  localparam logic [5:0]  CTRL_RST   = 6'h00;
  localparam logic [7:0]  GAIN_RST   = 8'h00;    // 0 dB
  localparam logic [11:0] OFSMAX_RST = 12'h0FF;
  localparam logic [15:0] GAP_RST    = 16'h0100; // min cycles between frame starts
  localparam logic [2:0]  IMASK_RST  = 3'h0;
  localparam int          BLK_SHIFT  = 3;        // black level averaging weight

  // readout states, Gray along the path
  typedef enum logic [1:0] {
    IFF_IDLE = 2'b00,
    IFF_LINE = 2'b01,
    IFF_LEND = 2'b11,
    IFF_DONE = 2'b10
  } iff_state_e;

endpackage

// >>> iff_top.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module iff_top
  import iff_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // sensor side
  input  wire logic          sensor_colour,
  input  wire logic          sen_frame,
  input  wire logic          sen_line,
  input  wire logic          sen_valid,
  input  wire logic          sen_dark,
  input  wire logic [DW-1:0] sen_pix,
  output logic [7:0]         afe_gain,
  output logic               sen_bin_h,
  output logic               sen_bin_v,
  // host link side
  input  wire logic          out_ready,
  output logic [DW-1:0]      out_pix,
  output logic [1:0]         out_colour,
  output logic               pixel_valid_flag,
  output logic               line_valid_flag,
  output logic               frame_valid_flag,
  output logic               irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [5:0]             ctrl;
    logic [7:0]             gain;
    logic [11:0]            ofs_max;
    logic [15:0]            gap;
    logic [2:0]             ist;
    logic [2:0]             imask;
    logic [31:0]            prdata;
    logic [DW-1:0]          blk;
    logic                   frame_d;
    logic                   line_d;
    logic                   capture;
    logic [4:0]             wx;
    logic [3:0]             wy;
    logic [4:0]             wlen;
    logic                   line_wr;
    logic [2:0]             c6;
    logic [2:0]             r6;
    logic [1:0]             c3;
    logic [1:0]             wslot;
    logic [1:0]             rslot;
    logic [2:0]             count;
    logic [SLOTS-1:0][4:0]  fwid;
    logic [SLOTS-1:0][3:0]  fhgt;
    iff_state_e             st;
    logic [15:0]            gap_cnt;
    logic [4:0]             rx;
    logic [3:0]             ry;
    logic [DW-1:0]          opix;
    logic [1:0]             ocol;
    logic                   opv;
    logic                   olv;
    logic                   ofv;
  } iff_top_s;

  iff_top_s         s_reg;
  iff_top_s         s_next;
  logic [DW-1:0]    mem [MEMW];
  logic             mem_we;
  logic [8:0]       mem_wa;
  logic [DW-1:0]    mem_wd;
  logic [8:0]       mem_ra;

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  logic             acc;
  logic             hit;
  logic             mono;
  logic             bin2;
  logic             ckeep;
  logic             rkeep;
  logic             pv3;
  logic             ev_drop;
  logic             ev_stored;
  logic             ev_sent;
  logic [4:0]       sx;
  logic [3:0]       sy;
  logic [4:0]       fw;
  logic [3:0]       fh;
  logic signed [DW+1:0] bdiff;
  logic [DW-1:0]    bnew;
  logic             frise;
  logic             lrise;
  logic             cap_cur;
  logic [2:0]       c6_cur;
  logic [2:0]       r6_cur;
  logic [1:0]       c3_cur;
  logic [4:0]       wx_cur;
  logic [3:0]       wy_cur;

  assign acc   = psel && penable;
  assign mono  = !sensor_colour;
  // a sensor may raise its line or frame strobe together with the first pixel;
  // that pixel must see the freshly cleared counters, not the ones left over
  // from the previous line or frame, or it lands in the wrong column
  assign frise   = sen_frame && !s_reg.frame_d;
  assign lrise   = sen_line && !s_reg.line_d;
  assign cap_cur = frise ? (s_reg.count != SLOTS_C) : s_reg.capture;
  assign c6_cur  = lrise ? 3'h0 : s_reg.c6;
  assign c3_cur  = lrise ? 2'h0 : s_reg.c3;
  assign wx_cur  = lrise ? 5'h00 : s_reg.wx;
  assign r6_cur  = frise ? 3'h0 : s_reg.r6;
  assign wy_cur  = frise ? 4'h0 : s_reg.wy;
  // binning is only offered on monochrome sensors
  assign bin2  = mono && s_reg.ctrl[C_BIN_H] && s_reg.ctrl[C_BIN_V];
  // decimation: mono keeps one column/row in three, colour keeps a 2x2 cell in six
  assign ckeep = !s_reg.ctrl[C_DEC] || (sensor_colour ? (c6_cur < 3'd2)
                 : (c6_cur == 3'd0 || c6_cur == 3'd3));
  // fewer stored rows and columns shorten the readout, which is where the
  // higher frame rate of colour decimation comes from
  assign rkeep = !s_reg.ctrl[C_DEC] || (sensor_colour ? (r6_cur < 3'd2)
                 : (r6_cur == 3'd0 || r6_cur == 3'd3));
  // two-by-two with pixel-valid enabled: only every third pixel is taken
  assign pv3   = !(bin2 && s_reg.ctrl[C_PV_EN]) || (c3_cur == 2'd0);

  // address decode
  always_comb begin
    unique case (paddr)
      A_CTRL, A_GAIN, A_OFSMAX, A_GAP, A_STATUS, A_ISTAT, A_IMASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // running black level from shielded pixels, clamped to the ceiling
  // the shift lets the level follow slow dark drift without chasing noise
  always_comb begin
    bdiff = $signed({2'b00, sen_pix}) - $signed({2'b00, s_reg.blk});
    bnew  = DW'(s_reg.blk + DW'(bdiff >>> BLK_SHIFT));
    if (bnew > s_reg.ofs_max) begin
      bnew = s_reg.ofs_max;
    end
  end

  // mirrored read address within the current slot
  // mirror bits are read live, so software changes them between frames
  always_comb begin
    fw = s_reg.fwid[s_reg.rslot];
    fh = s_reg.fhgt[s_reg.rslot];
    sx = s_reg.ctrl[C_MIR_H] ? 5'(fw - 5'd1 - s_reg.rx) : s_reg.rx;
    sy = s_reg.ctrl[C_MIR_V] ? 4'(fh - 4'd1 - s_reg.ry) : s_reg.ry;
    mem_ra = {s_reg.rslot, sy[2:0], sx[3:0]};
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    s_next    = s_reg;
    mem_we    = 1'b0;
    // write address follows the counters that the current pixel sees
    mem_wa    = {s_reg.wslot, wy_cur[2:0], wx_cur[3:0]};
    mem_wd    = (sen_pix > s_reg.blk) ? DW'(sen_pix - s_reg.blk) : '0;
    ev_drop   = 1'b0;
    ev_stored = 1'b0;
    ev_sent   = 1'b0;

    // apb: read data captured in the setup cycle, writes in the access cycle
    if (psel && !penable) begin
      unique case (paddr)
        A_CTRL:   s_next.prdata = {26'h0, s_reg.ctrl};
        A_GAIN:   s_next.prdata = {24'h0, s_reg.gain};
        A_OFSMAX: s_next.prdata = {20'h0, s_reg.ofs_max};
        A_GAP:    s_next.prdata = {16'h0, s_reg.gap};
        A_STATUS: s_next.prdata = {12'h0, s_reg.blk, 4'h0,
                                   s_reg.count == SLOTS_C, s_reg.count};
        A_ISTAT:  s_next.prdata = {29'h0, s_reg.ist};
        A_IMASK:  s_next.prdata = {29'h0, s_reg.imask};
        default:  s_next.prdata = 32'h0;
      endcase
    end
    if (acc && pwrite) begin
      unique case (paddr)
        A_CTRL:   s_next.ctrl    = pwdata[5:0];
        A_GAIN:   s_next.gain    = pwdata[7:0];
        A_OFSMAX: s_next.ofs_max = pwdata[11:0];
        A_GAP:    s_next.gap     = pwdata[15:0];
        A_ISTAT:  s_next.ist     = s_reg.ist & ~pwdata[2:0];
        A_IMASK:  s_next.imask   = pwdata[2:0];
        default:  ;
      endcase
    end

    // capture: sensor edges
    s_next.frame_d = sen_frame;
    s_next.line_d  = sen_line;
    // a full buffer refuses the whole frame; stored frames are never overwritten
    if (sen_frame && !s_reg.frame_d) begin
      s_next.wy = '0;
      s_next.r6 = '0;
      if (s_reg.count == SLOTS_C) begin
        s_next.capture = 1'b0;
        ev_drop        = 1'b1;
      end else begin
        s_next.capture = 1'b1;
      end
    end
    // line start: column counters and the line-written mark restart
    if (sen_line && !s_reg.line_d) begin
      s_next.wx      = '0;
      s_next.c6      = '0;
      s_next.c3      = '0;
      s_next.line_wr = 1'b0;
    end

    // pixels: dark ones feed the black level, active ones go to memory
    if (sen_frame && sen_line && sen_valid) begin
      if (sen_dark) begin
        s_next.blk = bnew;
      end else begin
        // column phase counters run on every active pixel, kept or not
        s_next.c6 = (c6_cur == 3'd5) ? 3'd0 : 3'(c6_cur + 3'd1);
        s_next.c3 = (c3_cur == 2'd2) ? 2'd0 : 2'(c3_cur + 2'd1);
        // pixels beyond the stored width or height are ignored
        if (cap_cur && ckeep && rkeep && pv3 &&
            wx_cur < MAXW_C && wy_cur < MAXH_C) begin
          mem_we         = 1'b1;
          s_next.wx      = 5'(wx_cur + 5'd1);
          s_next.line_wr = 1'b1;
        end
      end
    end

    // line end: advance row counters
    if (!sen_line && s_reg.line_d) begin
      s_next.r6 = (s_reg.r6 == 3'd5) ? 3'd0 : 3'(s_reg.r6 + 3'd1);
      if (s_reg.line_wr) begin
        s_next.wy   = 4'(s_reg.wy + 4'd1);
        s_next.wlen = s_reg.wx;
      end
    end

    // frame end: commit the slot in acquisition order
    if (!sen_frame && s_reg.frame_d && s_reg.capture) begin
      s_next.capture = 1'b0;
      if (s_reg.wy != 4'd0) begin
        s_next.fwid[s_reg.wslot] = s_reg.wlen;
        s_next.fhgt[s_reg.wslot] = s_reg.wy;
        s_next.wslot             = 2'(s_reg.wslot + 2'd1);
        ev_stored                = 1'b1;
      end
    end

    // frame-start spacing counter
    // it caps the outgoing frame rate whatever the sensor delivers
    if (s_reg.gap_cnt != 16'h0) begin
      s_next.gap_cnt = 16'(s_reg.gap_cnt - 16'd1);
    end

    // readout to the host link, stalls on out_ready
    unique case (s_reg.st)
      IFF_IDLE: begin
        if (s_reg.count != 3'd0 && s_reg.gap_cnt == 16'h0) begin
          s_next.gap_cnt = s_reg.gap;
          s_next.rx      = '0;
          s_next.ry      = '0;
          s_next.ofv     = 1'b1;
          s_next.st      = IFF_LINE;
        end
      end
      IFF_LINE: begin
        if (!s_reg.opv || out_ready) begin
          if (s_reg.rx < fw) begin
            s_next.opix = mem[mem_ra];
            s_next.ocol = {sy[0], sx[0]};
            s_next.opv  = 1'b1;
            s_next.olv  = 1'b1;
            s_next.rx   = 5'(s_reg.rx + 5'd1);
          end else begin
            s_next.opv = 1'b0;
            s_next.olv = 1'b0;
            s_next.st  = IFF_LEND;
          end
        end
      end
      // two dead cycles between lines, IFF_LEND and the first IFF_LINE fetch, keep line valid low for the host
      IFF_LEND: begin
        s_next.ry = 4'(s_reg.ry + 4'd1);
        s_next.rx = '0;
        if (4'(s_reg.ry + 4'd1) == fh) begin
          s_next.ofv = 1'b0;
          s_next.st  = IFF_DONE;
        end else begin
          s_next.st = IFF_LINE;
        end
      end
      // the slot is released only after its last line has gone out
      IFF_DONE: begin
        s_next.rslot = 2'(s_reg.rslot + 2'd1);
        ev_sent      = 1'b1;
        s_next.st    = IFF_IDLE;
      end
    endcase

    // stored frame count
    // a commit and a delivery in one cycle leave the count unchanged
    if (ev_stored && !ev_sent) begin
      s_next.count = 3'(s_reg.count + 3'd1);
    end else if (ev_sent && !ev_stored) begin
      s_next.count = 3'(s_reg.count - 3'd1);
    end

    // sticky events, set wins over a same-cycle clear
    s_next.ist = s_next.ist | {ev_sent, ev_stored, ev_drop};
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg         <= '0;
      s_reg.ctrl    <= CTRL_RST;
      s_reg.gain    <= GAIN_RST;
      s_reg.ofs_max <= OFSMAX_RST;
      s_reg.gap     <= GAP_RST;
      s_reg.imask   <= IMASK_RST;
      s_reg.st      <= IFF_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // frame memory, no reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata           = s_reg.prdata;
  assign pready           = 1'b1;
  assign pslverr          = acc && !hit;
  assign afe_gain         = s_reg.gain;
  assign sen_bin_h        = mono && s_reg.ctrl[C_BIN_H];
  assign sen_bin_v        = mono && s_reg.ctrl[C_BIN_V];
  assign out_pix          = s_reg.opix;
  assign out_colour       = s_reg.ocol;
  assign pixel_valid_flag = s_reg.opv;
  assign line_valid_flag  = s_reg.olv;
  assign frame_valid_flag = s_reg.ofv;
  assign irq              = |(s_reg.ist & s_reg.imask);

endmodule
`default_nettype wire

// >>> iff_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker
// ****************************************************************
module iff_props
  import iff_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic          sensor_colour,
  input wire logic [7:0]    afe_gain,
  input wire logic          sen_bin_h,
  input wire logic          sen_bin_v,
  input wire logic          out_ready,
  input wire logic [DW-1:0] out_pix,
  input wire logic          pixel_valid_flag,
  input wire logic          line_valid_flag,
  input wire logic          frame_valid_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // binning, qualifiers, stall hold, gain source
  a_bin_mono: assert property (sensor_colour [*2] |-> !sen_bin_h && !sen_bin_v)
    else $error("binning on colour sensor");
  a_lv_in_fv: assert property (line_valid_flag |-> frame_valid_flag)
    else $error("line valid outside frame");
  a_pv_in_lv: assert property (pixel_valid_flag |-> line_valid_flag)
    else $error("pixel valid outside line");
  a_pix_hold: assert property (pixel_valid_flag && !out_ready |=> pixel_valid_flag && $stable(out_pix))
    else $error("pixel lost during stall");
  a_frame_lead: assert property ($rose(frame_valid_flag) |=> line_valid_flag && pixel_valid_flag)
    else $error("first line late");
  a_line_gap: assert property ($fell(line_valid_flag) |=> !line_valid_flag)
    else $error("lines not separated");
  a_frame_gap: assert property ($fell(frame_valid_flag) |=> !frame_valid_flag)
    else $error("frames not separated");
  a_gain_write: assert property ($changed(afe_gain) |-> $past(psel && penable && pwrite && paddr == A_GAIN))
    else $error("gain changed without write");
  c_frame: cover property ($rose(frame_valid_flag));
  c_stall: cover property (pixel_valid_flag && !out_ready);
  c_bin: cover property (sen_bin_h && sen_bin_v);
endmodule
bind iff_top iff_props u_props (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .sensor_colour, .afe_gain, .sen_bin_h, .sen_bin_v, .out_ready, .out_pix,
  .pixel_valid_flag, .line_valid_flag, .frame_valid_flag);
`default_nettype wire

// >>> image_format_frame_buffer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// testbench
// ****************************************************************
module image_format_frame_buffer_test
  import iff_pkg::*;
;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic sensor_colour, sen_frame, sen_line, sen_valid, sen_dark, stall, slow;
  logic sen_bin_h, sen_bin_v, out_ready, pixel_valid_flag, line_valid_flag, frame_valid_flag;
  logic [7:0]    paddr, afe_gain;
  logic [31:0]   pwdata, prdata, rdat;
  logic [DW-1:0] sen_pix, out_pix;
  logic [1:0]    out_colour;
  int            mismatches, compares, rp, cyc;
  iff_top dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sensor_colour, .sen_frame, .sen_line, .sen_valid, .sen_dark,
    .sen_pix, .afe_gain, .sen_bin_h, .sen_bin_v, .out_ready, .out_pix, .out_colour,
    .pixel_valid_flag, .line_valid_flag, .frame_valid_flag, .irq);
  iff_host host (.ref_clk, .sys_rst, .stall, .slow, .pixel_valid_flag, .out_colour,
    .out_pix, .out_ready);
  // clock and hang limit
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e & m, rdat & m);
  endtask
  // one sensor frame of w by h pixels, value base + row*16 + col
  task automatic frm(input int w, input int h, input logic [11:0] b, input logic d);
    @(posedge ref_clk) sen_frame <= 1'b1;
    for (int r = 0; r < h; r++) begin
      for (int c = 0; c < w; c++) begin
        @(posedge ref_clk);
        sen_line  <= 1'b1;
        sen_valid <= 1'b1;
        sen_dark  <= d;
        sen_pix   <= b + 12'(r * 16 + c);
      end
      @(posedge ref_clk);
      sen_line  <= 1'b0;
      sen_valid <= 1'b0;
    end
    @(posedge ref_clk) sen_frame <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // next received pixel: colour from row/col parity, value less black level 5
  task automatic px(input int r, input int c, input logic [11:0] b);
    int t;
    logic [11:0] v;
    t = 0;
    v = b + 12'(r * 16 + c) - 12'h005;
    while (host.n <= rp && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
    chk("pixel", {18'h0, r[0], c[0], v}, {18'h0, host.got[rp]});
    rp++;
  endtask
  task automatic mode(input logic [31:0] ctl, input logic col, input int c1);
    sensor_colour <= col;
    wr(A_CTRL, ctl);
    frm(7, 1, 12'h300, 1'b0);
    px(0, 0, 12'h300);
    px(0, c1, 12'h300);
    px(0, 6, 12'h300);
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, sensor_colour, sen_frame, sen_line, sen_valid, sen_dark} = '0;
    {stall, slow, paddr, pwdata, sen_pix} = '0;
    {mismatches, compares, rp, cyc} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(A_GAIN, 32'h0, '1);
    chk("afe_gain", 32'h0, {24'h0, afe_gain});
    rd(A_OFSMAX, 32'h0FF, '1);
    rd(A_GAP, 32'h100, '1);
    rd(8'h40, 32'h0, '1);
    chk("slverr", 32'h1, {31'h0, rerr});
    wr(A_GAIN, 32'h20);
    @(posedge ref_clk);
    chk("afe_gain", 32'h20, {24'h0, afe_gain});
    wr(A_OFSMAX, 32'h5);
    frm(1, 1, 12'h040, 1'b1);
    rd(A_STATUS, 32'h500, 32'hFFF0F);
    slow <= 1'b1;
    frm(3, 2, 12'h100, 1'b0);
    for (int r = 0; r < 2; r++) for (int c = 0; c < 3; c++) px(r, c, 12'h100);
    slow <= 1'b0;
    wr(A_CTRL, 32'h3);
    frm(3, 2, 12'h200, 1'b0);
    for (int r = 1; r >= 0; r--) for (int c = 2; c >= 0; c--) px(r, c, 12'h200);
    mode(32'h10, 1'b0, 3);
    mode(32'h10, 1'b1, 1);
    mode(32'h2C, 1'b0, 3);
    chk("bins", 32'h3, {30'h0, sen_bin_h, sen_bin_v});
    sensor_colour <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("bins", 32'h0, {30'h0, sen_bin_h, sen_bin_v});
    sensor_colour <= 1'b0;
    wr(A_CTRL, 32'h0);
    wr(A_ISTAT, 32'h7);
    wr(A_IMASK, 32'h1);
    stall <= 1'b1;
    for (int k = 0; k < 5; k++) frm(2, 1, 12'h400 + 12'(k * 256), 1'b0);
    rd(A_STATUS, 32'hC, 32'hF);
    rd(A_ISTAT, 32'h1, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    stall <= 1'b0;
    for (int k = 0; k < 4; k++) for (int c = 0; c < 2; c++) px(0, c, 12'h400 + 12'(k * 256));
    repeat (300) @(posedge ref_clk);
    rd(A_STATUS, 32'h0, 32'hF);
    chk("frames", rp, host.n);
    wr(A_ISTAT, 32'h1);
    rd(A_ISTAT, 32'h0, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    print_verdict;
  end
endmodule
`default_nettype wire
